// file: src/i2c_port_if.sv
// interface: the two i2c bus lines with open-drain resolution
`timescale 1ns/100ps
`default_nettype none
interface i2c_port_if;
  logic scl_o_ctl;   // controller scl output (low drives)
  logic scl_oe_n_ctl; // controller scl enable, low while driving
  logic sda_o_ctl;   // controller sda output
  logic sda_oe_n_ctl; // controller sda enable, low while driving
  logic sda_o_tgt;   // target sda output
  logic sda_oe_n_tgt; // target sda enable, low while driving
  logic scl;         // resolved scl level
  logic sda;         // resolved sda level
  // wired-and with pull-up
  assign scl = (!scl_oe_n_ctl) ? scl_o_ctl : 1'b1;
  assign sda = ((!sda_oe_n_ctl) ? sda_o_ctl : 1'b1) & ((!sda_oe_n_tgt) ? sda_o_tgt : 1'b1);
  modport target (input scl, input sda, output sda_o_tgt, output sda_oe_n_tgt);
  modport controller (input scl, input sda, output scl_o_ctl, output scl_oe_n_ctl,
                      output sda_o_ctl, output sda_oe_n_ctl);
endinterface : i2c_port_if
`default_nettype wire

// file: src/i2c_port_pkg.sv
// package: constants shared by the i2c target port and its controller
package i2c_port_pkg;
  localparam logic [6:0] ADDR_LO       = 7'h18;  // lowest legal target address
  localparam logic [6:0] ADDR_HI       = 7'h1F;  // highest legal target address
  localparam logic [4:0] MASTER_CODE_HI = 5'h01; // upper bits of master code 00001xxx
  localparam logic [6:0] ACCESS_CODE   = 7'h08;  // master code 08H, sent as byte 00001000
  localparam int         CLK_HZ        = 25000000;
  localparam int         FS_RATE_BPS   = 400000;  // fast mode bit rate
  localparam int         HS_RATE_BPS   = 3400000; // high-speed bit rate
  // half period of scl in clk cycles, longest time rounds down, min one
  localparam int         FS_HALF_CYC   = (CLK_HZ / (2 * FS_RATE_BPS)) < 1 ? 1 :
                                         (CLK_HZ / (2 * FS_RATE_BPS));
  localparam int         HS_HALF_CYC   = (CLK_HZ / (2 * HS_RATE_BPS)) < 1 ? 1 :
                                         (CLK_HZ / (2 * HS_RATE_BPS));
  localparam int         REG_W         = 8;       // register and data width
endpackage : i2c_port_pkg

// file: src/pmic_i2c_controller.sv
// controller end: generates scl, writes or reads byte streams, optional hs preamble
`timescale 1ns/100ps
`default_nettype none
module pmic_i2c_controller (
  input  wire logic        clk,       // system clock
  input  wire logic        arst_n,    // async reset, active low
  i2c_port_if.controller   bus,       // i2c lines
  input  wire logic        go,        // start a transaction, pulse
  input  wire logic        use_hs,    // precede with master code
  input  wire logic        rnw,       // 1 read, 0 write
  input  wire logic [6:0]  dev_addr,  // target address
  input  wire logic [7:0]  reg_addr,  // register address
  input  wire logic [3:0]  nbytes,    // data bytes, at least one
  input  wire logic [7:0]  wdata,     // next write byte
  output logic             wnext_q,   // pulse: wdata taken
  output logic [7:0]       rdata_q,   // read byte
  output logic             rvalid_q,  // pulse: rdata valid
  output logic             busy_q,    // transaction running
  output logic             nack_q     // target did not acknowledge
);
  // bit-level sequencer, one bit slot per three half-period ticks
  typedef enum logic [2:0] {C_IDLE, C_START, C_BIT, C_SR, C_STOP} cst_e;
  cst_e        st_q, st_d;
  logic [7:0]  byte_q, byte_d, rd_d;
  logic [3:0]  bit_q, bit_d, left_q, left_d;
  logic [2:0]  ph_q, ph_d;            // phase: 0 hs code, 1 addr-w, 2 reg, 3 wdata, 4 addr-r, 5 rdata
  logic [7:0]  div_q, div_d;
  logic [1:0]  sub_q, sub_d;
  logic        hs_q, hs_d, scl_d, sda_d, wn_d, rv_d, nk_d, by_d, rnw_q, rnw_d;
  logic        scl_q, sda_q, tick;
  logic [1:0]  sda_s_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) sda_s_q <= 2'h3;
    else sda_s_q <= {sda_s_q[0], bus.sda};
  end
  assign tick = (div_q == 8'h00);

  always_comb
  begin
    st_d = st_q; byte_d = byte_q; bit_d = bit_q; left_d = left_q; ph_d = ph_q;
    hs_d = hs_q; scl_d = scl_q; sda_d = sda_q; wn_d = 1'b0; rv_d = 1'b0;
    nk_d = nack_q; by_d = busy_q; rd_d = rdata_q; sub_d = sub_q; rnw_d = rnw_q;
    div_d = tick ? 8'((hs_q ? i2c_port_pkg::HS_HALF_CYC : i2c_port_pkg::FS_HALF_CYC) - 1)
                 : div_q - 8'h01;
    unique case (st_q)
      C_IDLE:
        if (go)
        begin
          by_d = 1'b1; nk_d = 1'b0; rnw_d = rnw; left_d = (nbytes == 4'h0) ? 4'h1 : nbytes;
          ph_d = use_hs ? 3'h0 : 3'h1;
          byte_d = use_hs ? {1'b0, i2c_port_pkg::ACCESS_CODE} : {dev_addr, 1'b0};
          st_d = C_START; sub_d = 2'h0; div_d = 8'h00;
        end
      C_START, C_SR:
        if (tick)
        begin
          sub_d = sub_q + 2'h1;
          // release sda while scl low, so a repeated start keeps a full scl period
          unique case (sub_q)
            2'h0: sda_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b0;
            default: begin scl_d = 1'b0; st_d = C_BIT; bit_d = 4'h0; sub_d = 2'h0; end
          endcase
        end
      C_BIT:
        if (tick)
        begin
          sub_d = sub_q + 2'h1;
          if (sub_q == 2'h0)
            sda_d = (bit_q == 4'h8) ? (ph_q == 3'h5 ? (left_q == 4'h1) : 1'b1)
                  : (ph_q == 3'h5 ? 1'b1 : byte_q[7]);
          else if (sub_q == 2'h1) scl_d = 1'b1;
          else if (sub_q == 2'h2)
          begin
            if (bit_q != 4'h8) byte_d = {byte_q[6:0], sda_s_q[1]};
            scl_d = 1'b0; sub_d = 2'h0; bit_d = bit_q + 4'h1;
            if (bit_q == 4'h8)
            begin
              bit_d = 4'h0;
              if (ph_q == 3'h0)
              begin
                hs_d = 1'b1; st_d = C_SR; ph_d = 3'h1;          // nack expected
                byte_d = {dev_addr, 1'b0};
              end
              else if (ph_q != 3'h5 && sda_s_q[1])
              begin
                nk_d = 1'b1; st_d = C_STOP;
              end
              else if (ph_q == 3'h1)
              begin
                ph_d = 3'h2; byte_d = reg_addr;
              end
              else if (ph_q == 3'h2 && rnw_q)
              begin
                ph_d = 3'h4; st_d = C_SR; byte_d = {dev_addr, 1'b1};
              end
              else if (ph_q == 3'h4)
                ph_d = 3'h5;
              else
              begin
                if (ph_q == 3'h5)
                begin
                  rd_d = byte_q; rv_d = 1'b1;
                end
                if (ph_q >= 3'h3) left_d = left_q - 4'h1;
                if (ph_q >= 3'h3 && left_q == 4'h1) st_d = C_STOP;
                else if (ph_q != 3'h5)
                begin
                  ph_d = 3'h3; byte_d = wdata; wn_d = 1'b1;
                end
              end
            end
          end
        end
      C_STOP:
        if (tick)
        begin
          sub_d = sub_q + 2'h1;
          unique case (sub_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default: begin st_d = C_IDLE; by_d = 1'b0; hs_d = 1'b0; end
          endcase
        end
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= C_IDLE; byte_q <= 8'h00; bit_q <= 4'h0; left_q <= 4'h0; ph_q <= 3'h0;
      hs_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1; wnext_q <= 1'b0; rvalid_q <= 1'b0;
      nack_q <= 1'b0; busy_q <= 1'b0; rdata_q <= 8'h00; sub_q <= 2'h0; div_q <= 8'h00;
      rnw_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; byte_q <= byte_d; bit_q <= bit_d; left_q <= left_d; ph_q <= ph_d;
      hs_q <= hs_d; scl_q <= scl_d; sda_q <= sda_d; wnext_q <= wn_d; rvalid_q <= rv_d;
      nack_q <= nk_d; busy_q <= by_d; rdata_q <= rd_d; sub_q <= sub_d; div_q <= div_d;
      rnw_q <= rnw_d;
    end
  end
  // open drain lines
  assign bus.scl_o_ctl    = 1'b0;
  assign bus.scl_oe_n_ctl = scl_q;
  assign bus.sda_o_ctl    = 1'b0;
  assign bus.sda_oe_n_ctl = sda_q;
endmodule : pmic_i2c_controller
`default_nettype wire

// file: src/pmic_i2c_target_port.sv
// target end: address match, register address and data byte streams
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - commands only after supply up and boot done
// - answer one factory address within 18h..1Fh
// - fast mode up to 400 kb/s
// - one or more data bytes after address
// - high-speed mode up to 3.4 Mb/s
// - master code 00001xxx is never acknowledged
module pmic_i2c_target_port #(
  parameter logic [6:0] TARGET_ADDR = 7'h18  // factory address
) (
  input  wire logic          clk,            // system clock
  input  wire logic          arst_n,         // async reset, active low
  i2c_port_if.target         bus,            // i2c lines
  input  wire logic          logic_supply_ok, // digital_logic_supply up
  input  wire logic          boot_done,      // converter boot completed
  input  wire logic [7:0]    rd_data,        // register read data
  output logic               wr_stb_q,       // one-cycle write strobe
  output logic               rd_stb_q,       // one-cycle read strobe
  output logic [7:0]         reg_addr_q,     // register address
  output logic [7:0]         wr_data_q,      // write data
  output logic               hs_mode_q       // high-speed mode active
);
  // refuse a factory address outside the legal range at elaboration
  if (TARGET_ADDR < i2c_port_pkg::ADDR_LO || TARGET_ADDR > i2c_port_pkg::ADDR_HI)
  begin : g_bad_addr
    $error("target address out of range");
  end

  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, REGA, WDATA, RDATA, ACK, RACK} st_e;

  // two-flop sync of bus lines and enable levels, fast enough for fs and hs
  logic [1:0] scl_s_q, sda_s_q, sup_s_q, boot_s_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      sup_s_q  <= 2'h0;
      boot_s_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], bus.scl};
      sda_s_q <= {sda_s_q[0], bus.sda};
      sup_s_q  <= {sup_s_q[0], logic_supply_ok};
      boot_s_q <= {boot_s_q[0], boot_done};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  logic scl, sda, enabled, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign enabled  = sup_s_q[1] & boot_s_q[1];
  assign scl_rise = scl & !scl_p_q;
  assign scl_fall = !scl & scl_p_q;
  assign start_c  = scl & scl_p_q & sda_p_q & !sda;
  assign stop_c   = scl & scl_p_q & !sda_p_q & sda;

  st_e        st_q, st_d, nxt_q, nxt_d;
  logic [7:0] sh_q, sh_d, addr_d, wd_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d, drv_q, drv_d, hs_d, wr_d, rd_d, regset_q, regset_d;

  // protocol next-state logic
  always_comb
  begin
    st_d = st_q; nxt_d = nxt_q; sh_d = sh_q; cnt_d = cnt_q; rw_d = rw_q;
    drv_d = drv_q; hs_d = hs_mode_q; wr_d = 1'b0; rd_d = 1'b0;
    addr_d = reg_addr_q; wd_d = wr_data_q; regset_d = regset_q;
    if (!enabled)
    begin
      st_d = IDLE; drv_d = 1'b0; hs_d = 1'b0;
    end
    else if (stop_c)
    begin
      st_d = IDLE; drv_d = 1'b0; hs_d = 1'b0;
    end
    else if (start_c)
    begin
      st_d = ADDR; cnt_d = 4'h0; drv_d = 1'b0;       // hs kept
    end
    else
    begin
      unique case (st_q)
        IDLE: ;
        ADDR, REGA, WDATA:
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            cnt_d = 4'h0;
            if (st_q == ADDR)
            begin
              if (sh_q[7:3] == i2c_port_pkg::MASTER_CODE_HI)
              begin
                hs_d = 1'b1; st_d = IDLE;            // no ack, wait for sr
              end
              else if (sh_q[7:1] == TARGET_ADDR)
              begin
                rw_d = sh_q[0]; drv_d = 1'b1; st_d = ACK;
                nxt_d = sh_q[0] ? RDATA : REGA;
                regset_d = 1'b0;
              end
              else st_d = IDLE;
            end
            else if (st_q == REGA)
            begin
              addr_d = sh_q; drv_d = 1'b1; st_d = ACK; nxt_d = WDATA;
            end
            else
            begin
              wd_d = sh_q; wr_d = 1'b1; drv_d = 1'b1; st_d = ACK;
              nxt_d = WDATA;
            end
          end
        ACK:
          if (scl_fall)
          begin
            drv_d = 1'b0; st_d = nxt_q; cnt_d = 4'h0;
            if (nxt_q == WDATA && regset_q) addr_d = reg_addr_q + 8'h01; // stream
            if (nxt_q == WDATA) regset_d = 1'b1;
            if (nxt_q == RDATA)
            begin
              sh_d = rd_data; rd_d = 1'b1; drv_d = !rd_data[7];
              cnt_d = 4'h1;
            end
          end
        RDATA:
          if (scl_fall)
          begin
            if (cnt_q == 4'h8)
            begin
              drv_d = 1'b0; st_d = RACK;
            end
            else
            begin
              drv_d = !sh_q[7 - cnt_q[2:0]];
              cnt_d = cnt_q + 4'h1;
            end
          end
        RACK:
          if (scl_rise)
          begin
            if (sda) st_d = IDLE;                    // nack ends read
            else
            begin
              st_d = ACK; nxt_d = RDATA;             // more bytes
              addr_d = reg_addr_q + 8'h01;
            end
          end
        default: st_d = IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= IDLE; nxt_q <= IDLE; sh_q <= 8'h00; cnt_q <= 4'h0; rw_q <= 1'b0;
      drv_q <= 1'b0; hs_mode_q <= 1'b0; wr_stb_q <= 1'b0; rd_stb_q <= 1'b0;
      reg_addr_q <= 8'h00; wr_data_q <= 8'h00; regset_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; nxt_q <= nxt_d; sh_q <= sh_d; cnt_q <= cnt_d; rw_q <= rw_d;
      drv_q <= drv_d; hs_mode_q <= hs_d; wr_stb_q <= wr_d; rd_stb_q <= rd_d;
      reg_addr_q <= addr_d; wr_data_q <= wd_d; regset_q <= regset_d;
    end
  end
  // open drain: drive low only
  assign bus.sda_o_tgt    = 1'b0;
  assign bus.sda_oe_n_tgt = !drv_q;
endmodule : pmic_i2c_target_port
`default_nettype wire

// file: verification/pmic_i2c_target_port_assertions.sv
// checker: bus behaviour of the i2c target port
`timescale 1ns/100ps
`default_nettype none
module pmic_i2c_target_port_assertions #(
  parameter logic [6:0] TARGET_ADDR = 7'h18  // address under check
) (
  input wire logic clk,             // system clock
  input wire logic arst_n,          // async reset, active low
  input wire logic scl,             // resolved clock line
  input wire logic sda,             // resolved data line
  input wire logic sda_oe_n_tgt,    // target data enable
  input wire logic logic_supply_ok, // supply up
  input wire logic boot_done,       // boot finished
  input wire logic hs_mode_q,       // high-speed flag
  input wire logic wr_stb_q,        // write strobe
  input wire logic rd_stb_q         // read strobe
);
  logic       scl_q, sda_q, first_q, first_d, rise, start, stop, ack;
  logic [3:0] bc_q, bc_d;
  logic [7:0] sh_q, sh_d, per_q, per_d;
  // line events
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign ack   = rise & (bc_q == 4'h8) & first_q;
  // bit count, shifted byte and scl period
  always_comb
  begin
    bc_d    = bc_q;
    sh_d    = sh_q;
    first_d = first_q;
    per_d   = (per_q == 8'hFF) ? per_q : per_q + 8'h01;
    if (rise)
      per_d = 8'h00;
    if (start)
    begin
      bc_d    = 4'h0;
      first_d = 1'b1;
    end
    else if (rise && bc_q == 4'h8)
    begin
      bc_d    = 4'h0;
      first_d = 1'b0;
    end
    else if (rise)
    begin
      sh_d = {sh_q[6:0], sda};
      bc_d = bc_q + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      first_q <= 1'b0;
      bc_q    <= 4'h0;
      sh_q    <= 8'h00;
      per_q   <= 8'hFF;
    end
    else
    begin
      scl_q   <= scl;
      sda_q   <= sda;
      first_q <= first_d;
      bc_q    <= bc_d;
      sh_q    <= sh_d;
      per_q   <= per_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_off_quiet: assert property (
    (!logic_supply_ok)[*6] |-> sda_oe_n_tgt && !wr_stb_q && !rd_stb_q)
    else $error("target active while supply down");
  a_off_no_hs: assert property (
    (!boot_done)[*6] |-> !hs_mode_q) else $error("hs mode while boot not done");
  a_scl_rate: assert property (
    rise |-> per_q >= 8'h07) else $error("scl period too short");
  a_mcode_nack: assert property (
    ack && sh_q[7:3] == i2c_port_pkg::MASTER_CODE_HI |-> sda)
    else $error("master code acknowledged");
  a_addr_other: assert property (
    ack && sh_q[7:1] != TARGET_ADDR |-> sda) else $error("foreign address acknowledged");
  a_addr_ack: assert property (
    ack && sh_q[7:1] == TARGET_ADDR && logic_supply_ok && boot_done |-> !sda)
    else $error("own address not acknowledged");
  a_stop_exit: assert property (
    stop |-> ##[1:8] !hs_mode_q) else $error("hs mode kept after stop");
  a_hold_sr: assert property (
    start && hs_mode_q |-> hs_mode_q[*4]) else $error("hs mode lost at repeated start");
endmodule : pmic_i2c_target_port_assertions
`default_nettype wire

// file: verification/pmic_i2c_target_port_test.sv
// testbench: controller and target joined over one i2c bus
`timescale 1ns/100ps
`default_nettype none
module pmic_i2c_target_port_test;
  localparam logic [6:0] TGT = 7'h1B;  // factory address used here
  logic       clk, arst_n, go, use_hs, rnw, logic_supply_ok, boot_done, hs_seen;
  logic       wr_stb_q, rd_stb_q, hs_mode_q, wnext_q, rvalid_q, busy_q, nack_q;
  logic [6:0] dev_addr;
  logic [7:0] reg_addr, wdata, rd_data, reg_addr_q, wr_data_q, rdata_q;
  logic [3:0] nbytes;
  logic [7:0] mem [256];
  logic [7:0] wbuf [8];
  logic [7:0] rq [$];
  int         widx, nwr, errors, n_checks, cyc;
  i2c_port_if bus_if ();
  pmic_i2c_target_port #(.TARGET_ADDR(TGT)) i_pmic_i2c_target_port (.clk(clk),
    .arst_n(arst_n), .bus(bus_if), .logic_supply_ok(logic_supply_ok),
    .boot_done(boot_done), .rd_data(rd_data), .wr_stb_q(wr_stb_q), .rd_stb_q(rd_stb_q),
    .reg_addr_q(reg_addr_q), .wr_data_q(wr_data_q), .hs_mode_q(hs_mode_q));
  pmic_i2c_controller i_pmic_i2c_controller (.clk(clk), .arst_n(arst_n), .bus(bus_if),
    .go(go), .use_hs(use_hs), .rnw(rnw), .dev_addr(dev_addr), .reg_addr(reg_addr),
    .nbytes(nbytes), .wdata(wdata), .wnext_q(wnext_q), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .busy_q(busy_q), .nack_q(nack_q));
  pmic_i2c_target_port_assertions #(.TARGET_ADDR(TGT)) i_pmic_i2c_target_port_assertions (
    .clk(clk), .arst_n(arst_n), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_oe_n_tgt(bus_if.sda_oe_n_tgt), .logic_supply_ok(logic_supply_ok),
    .boot_done(boot_done), .hs_mode_q(hs_mode_q), .wr_stb_q(wr_stb_q), .rd_stb_q(rd_stb_q));
  // register file behind the target
  assign rd_data = mem[reg_addr_q];
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // register writes, read capture, write feed and cycle limit
  always @(posedge clk)
  begin
    if (wr_stb_q)
    begin
      mem[reg_addr_q] <= wr_data_q;
      nwr <= nwr + 1;
    end
    if (rvalid_q)
      rq.push_back(rdata_q);
    if (wnext_q)
    begin
      widx  <= widx + 1;
      wdata <= wbuf[widx + 1];
    end
    if (hs_mode_q)
      hs_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      errors++;
      $display("[ERR] cycles expected below 80000 seen %0d", cyc);
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one transaction from go until busy falls
  task automatic xfer(input logic hs, input logic rd, input logic [6:0] da,
                      input logic [7:0] ra, input logic [3:0] n);
    int k;
    @(posedge clk);
    use_hs   <= hs;
    rnw      <= rd;
    dev_addr <= da;
    reg_addr <= ra;
    nbytes   <= n;
    wdata    <= wbuf[0];
    widx     <= 0;
    go       <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    k = 0;
    while (busy_q !== 1'b0 && k < 20000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : xfer
  task automatic t_fs;
    int i;
    wbuf[0] = 8'h3C;
    wbuf[1] = 8'hC3;
    wbuf[2] = 8'h5A;
    xfer(1'b0, 1'b0, TGT, 8'h10, 4'h3);
    chk("fs_nack", 8'h00, {7'h00, nack_q});
    for (i = 0; i < 3; i++)
      chk("fs_mem", wbuf[i], mem[8'h10 + i]);
    rq.delete();
    xfer(1'b0, 1'b1, TGT, 8'h10, 4'h3);
    chk("fs_rcount", 8'h03, 8'(rq.size()));
    for (i = 0; i < 3; i++)
      chk("fs_rd", wbuf[i], rq[i]);
    chk("fs_no_hs", 8'h00, {7'h00, hs_seen});
    $display("test fs done");
  endtask : t_fs
  task automatic t_hs;
    wbuf[0] = 8'h81;
    wbuf[1] = 8'h7E;
    rq.delete();
    xfer(1'b1, 1'b0, TGT, 8'hF0, 4'h2);
    chk("hs_mem0", 8'h81, mem[8'hF0]);
    chk("hs_mem1", 8'h7E, mem[8'hF1]);
    xfer(1'b1, 1'b1, TGT, 8'hF0, 4'h2);
    chk("hs_rd0", 8'h81, rq[0]);
    chk("hs_rd1", 8'h7E, rq[1]);
    chk("hs_seen", 8'h01, {7'h00, hs_seen});
    repeat (8) @(posedge clk);
    chk("hs_left", 8'h00, {7'h00, hs_mode_q});
    $display("test hs done");
  endtask : t_hs
  task automatic t_addr;
    int a;
    int n0;
    n0 = nwr;
    wbuf[0] = 8'h99;
    for (a = int'(i2c_port_pkg::ADDR_LO); a <= int'(i2c_port_pkg::ADDR_HI); a++)
      if (7'(a) != TGT)
      begin
        xfer(1'b0, 1'b0, 7'(a), 8'h40, 4'h1);
        chk("addr_nack", 8'h01, {7'h00, nack_q});
      end
    chk("addr_writes", 8'(n0), 8'(nwr));
    $display("test addr done");
  endtask : t_addr
  task automatic t_power;
    int k;
    wbuf[0] = 8'hEE;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk);
      if (k == 0)
        logic_supply_ok <= 1'b0;
      else
        boot_done <= 1'b0;
      repeat (8) @(posedge clk);
      xfer(1'b0, 1'b0, TGT, 8'h50, 4'h1);
      chk("off_nack", 8'h01, {7'h00, nack_q});
      chk("off_mem", 8'h00, mem[8'h50]);
      @(posedge clk);
      logic_supply_ok <= 1'b1;
      boot_done       <= 1'b1;
      repeat (8) @(posedge clk);
    end
    xfer(1'b0, 1'b0, TGT, 8'h50, 4'h1);
    chk("on_mem", 8'hEE, mem[8'h50]);
    $display("test power done");
  endtask : t_power
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // reset, then the scenarios in turn
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    {arst_n, go, use_hs, rnw, hs_seen} = 5'h00;
    {dev_addr, reg_addr, nbytes, wdata} = 27'h0;
    logic_supply_ok = 1'b1;
    boot_done       = 1'b1;
    {widx, nwr, errors, n_checks, cyc} = {5{32'h0}};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_fs();
    t_hs();
    t_addr();
    t_power();
    print_verdict();
  end
endmodule : pmic_i2c_target_port_test
`default_nettype wire
